// *** dnsd_pkg.sv ***
// Constants and carrier types for the group 2 slave message decoder
package dnsd_pkg;

    // ------------------------------------------------------------
    // Identifier layout
    // ------------------------------------------------------------
    localparam int          ID_W        = 11;
    localparam int          NODE_W      = 6;
    localparam logic [1:0]  GROUP2      = 2'h2;
    localparam logic [2:0]  MSG_DUPCHK  = 3'h7;
    localparam logic [2:0]  MSG_UNCONN  = 3'h6;
    localparam logic [2:0]  MSG_POLL    = 3'h5;
    localparam logic [2:0]  MSG_EXPL    = 3'h4;

    // ------------------------------------------------------------
    // Services, classes, attributes
    // ------------------------------------------------------------
    localparam logic [7:0]  SVC_GET     = 8'h0E;
    localparam logic [7:0]  SVC_SET     = 8'h10;
    localparam logic [7:0]  SVC_ALLOC   = 8'h4B;
    localparam logic [7:0]  SVC_RELEASE = 8'h4C;
    localparam logic [7:0]  CLS_IDENT   = 8'h01;
    localparam logic [7:0]  CLS_NET     = 8'h03;
    localparam logic [7:0]  CLS_CONN    = 8'h05;
    localparam logic [7:0]  CLS_CONSUME = 8'h64;
    localparam logic [7:0]  CLS_PRODUCE = 8'h65;
    localparam logic [7:0]  INST_ONE    = 8'h01;
    localparam logic [7:0]  ATTR_PCODE  = 8'h03;
    localparam logic [7:0]  ATTR_PSIZE  = 8'h07;
    localparam logic [7:0]  ATTR_CSIZE  = 8'h08;

    // ------------------------------------------------------------
    // Allocation choice bits and answer status
    // ------------------------------------------------------------
    localparam int          AL_EXPL     = 0;
    localparam int          AL_POLL     = 1;
    localparam int          AL_STROBE   = 2;
    localparam int          AL_COS      = 4;
    localparam logic [7:0]  AL_MASK     = 8'h17;
    localparam logic [7:0]  ST_OK       = 8'h00;
    localparam logic [7:0]  ST_SVC_NS   = 8'h08;
    localparam logic [7:0]  ST_BAD_VAL  = 8'h09;
    localparam logic [7:0]  ST_ATTR_NS  = 8'h14;
    localparam logic [7:0]  ST_NO_OBJ   = 8'h16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_ALLOC   = 8'h00;
    localparam logic [7:0]  RST_SIZE    = 8'h08;
    localparam logic [1:0]  RST_CNT     = 2'h0;

    typedef enum logic [1:0] {K_DUPCHK, K_EXPL, K_POLL} dnsd_kind_e;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [7:0]      service;
        logic [7:0]      cls;
        logic [7:0]      inst;
        logic [7:0]      attr;
        logic [15:0]     wdata;
    } dnsd_req_s;

    typedef struct packed {
        dnsd_kind_e      kind;
        logic [7:0]      service;
        logic [7:0]      cls;
        logic [7:0]      status;
        logic [15:0]     data;
    } dnsd_rsp_s;

endpackage

// *** dnsd_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dnsd_buf #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Filling side
    input  wire logic         s_valid,
    output var  logic         s_ready,
    input  wire logic [W-1:0] s_data,
    // Draining side
    output var  logic         m_valid,
    input  wire logic         m_ready,
    output var  logic [W-1:0] m_data
);
    import dnsd_pkg::*;

    generate
        if (W < 1)
        begin : g_bad_w
            $error("dnsd_buf width must be positive");
        end
    endgenerate

    logic [1:0]   cnt;
    logic [1:0]   next_cnt;
    logic [W-1:0] tail;
    logic [W-1:0] next_tail;
    logic [W-1:0] next_head;
    logic         push;
    logic         pop;

    // ------------------------------------------------------------
    // Occupancy
    // ------------------------------------------------------------
    // Head is the output register itself, so no mux sits after it
    always_comb
    begin
        push      = s_valid & s_ready;
        pop       = m_valid & m_ready;
        next_cnt  = cnt;
        next_head = m_data;
        next_tail = tail;
        unique case (cnt)
            2'h0:
            begin
                if (push)
                begin
                    next_head = s_data;
                    next_cnt  = 2'h1;
                end
            end
            2'h1:
            begin
                if (push && pop)
                    next_head = s_data;
                else if (push)
                begin
                    next_tail = s_data;
                    next_cnt  = 2'h2;
                end
                else if (pop)
                    next_cnt  = 2'h0;
            end
            2'h2:
            begin
                if (pop)
                begin
                    next_head = tail;
                    next_cnt  = 2'h1;
                end
            end
            default:
                next_cnt = RST_CNT;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt     <= RST_CNT;
            m_valid <= 1'b0;
            s_ready <= 1'b0;
            m_data  <= '0;
            tail    <= '0;
        end
        else
        begin
            cnt     <= next_cnt;
            m_valid <= (next_cnt != 2'h0);
            s_ready <= (next_cnt != 2'h2);
            m_data  <= next_head;
            tail    <= next_tail;
        end
    end

endmodule
`default_nettype wire

// *** dnsd_top.sv ***
// Group 2 slave identifier classifier and explicit service dispatcher
// ------------------------------------------------------------
// Overview of operation
// - Own-node id 10/node/111 is duplicate check
// - Own-node id 10/node/110 is unconnected request
// - Own-node id 10/node/101 is poll command
// - Own-node id 10/node/100 is connected explicit request
// - Middle six id bits compared to node
// - Service 0E reads, 10 writes one attribute
// - Service 4B allocates predefined connection set
// - Service 4C releases allocated connections
// - Accept classes 01, 03, 05, 64, 65
// - Identity instance 1 attribute 3 returns product code
// - Consumed and produced sizes 1 to 255
// - Poll, change-of-state and bit-strobe connections can be allocated; only poll messages are dispatched
// - No unconnected explicit manager; group 2 only
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module dnsd_top #(
    parameter logic [15:0] PRODUCT_CODE = 16'h0ABC  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // Node address switches
    input  wire logic [dnsd_pkg::NODE_W-1:0] node_addr,
    // Received messages
    input  wire logic                       req_valid,
    output var  logic                       req_ready,
    input  wire dnsd_pkg::dnsd_req_s        req,
    // Classified answers
    output var  logic                       rsp_valid,
    input  wire logic                       rsp_ready,
    output var  dnsd_pkg::dnsd_rsp_s        rsp,
    // Connection state
    output var  logic [7:0]                 alloc,
    output var  logic [7:0]                 consumed_size,
    output var  logic [7:0]                 produced_size
);
    import dnsd_pkg::*;

    logic [NODE_W-1:0] node_meta;
    logic [NODE_W-1:0] node_sync;
    logic              accept;
    logic              own;
    logic              push;
    dnsd_rsp_s         push_data;
    logic [7:0]        next_alloc;
    logic [7:0]        next_csize;
    logic [7:0]        next_psize;

    function automatic logic class_ok(input logic [7:0] c);
        class_ok = (c == CLS_IDENT) || (c == CLS_NET) || (c == CLS_CONN) ||
                   (c == CLS_CONSUME) || (c == CLS_PRODUCE);
    endfunction

    function automatic logic size_ok(input logic [15:0] v);
        size_ok = (v != 16'h0000) && (v <= 16'h00FF);
    endfunction

    // ------------------------------------------------------------
    // Node address synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            node_meta <= '0;
            node_sync <= '0;
        end
        else
        begin
            node_meta <= node_addr;
            node_sync <= node_meta;
        end
    end

    // ------------------------------------------------------------
    // Classification and dispatch
    // ------------------------------------------------------------
    // Ignored frames are still consumed so the receiver stalls on them only while the answer buffer is full
    always_comb
    begin
        accept     = req_valid & req_ready;
        own        = (req.id[10:9] == GROUP2) && (req.id[8:3] == node_sync);
        push       = 1'b0;
        push_data  = '0;
        next_alloc = alloc;
        next_csize = consumed_size;
        next_psize = produced_size;
        push_data.service = req.service;
        push_data.cls     = req.cls;
        if (accept && own)
        begin
            unique case (req.id[2:0])
                MSG_DUPCHK:
                begin
                    push           = 1'b1;
                    push_data.kind = K_DUPCHK;
                end
                MSG_POLL:
                begin
                    if (alloc[AL_POLL])
                    begin
                        push           = 1'b1;
                        push_data.kind = K_POLL;
                        push_data.data = {8'h00, consumed_size};
                    end
                end
                MSG_UNCONN, MSG_EXPL:
                begin
                    if (req.id[2:0] == MSG_UNCONN || alloc[AL_EXPL])
                    begin
                        push           = 1'b1;
                        push_data.kind = K_EXPL;
                        push_data.status = ST_OK;
                        if (req.service == SVC_ALLOC)
                            next_alloc = alloc | (req.wdata[7:0] & AL_MASK);
                        else if (req.service == SVC_RELEASE)
                            next_alloc = alloc & ~(req.wdata[7:0] & AL_MASK);
                        else if (req.id[2:0] == MSG_UNCONN)
                            push_data.status = ST_SVC_NS;
                        else if (!class_ok(req.cls))
                            push_data.status = ST_NO_OBJ;
                        else if (req.service == SVC_GET)
                        begin
                            if (req.cls == CLS_IDENT && req.inst == INST_ONE && req.attr == ATTR_PCODE)
                                push_data.data = PRODUCT_CODE;
                            else if (req.cls == CLS_CONN && req.attr == ATTR_CSIZE)
                                push_data.data = {8'h00, consumed_size};
                            else if (req.cls == CLS_CONN && req.attr == ATTR_PSIZE)
                                push_data.data = {8'h00, produced_size};
                            else
                                push_data.status = ST_ATTR_NS;
                        end
                        else if (req.service == SVC_SET)
                        begin
                            if (req.cls != CLS_CONN ||
                                (req.attr != ATTR_CSIZE && req.attr != ATTR_PSIZE))
                                push_data.status = ST_ATTR_NS;
                            else if (!size_ok(req.wdata))
                                push_data.status = ST_BAD_VAL;
                            else if (req.attr == ATTR_CSIZE)
                                next_csize = req.wdata[7:0];
                            else
                                next_psize = req.wdata[7:0];
                        end
                        else
                            push_data.status = ST_SVC_NS;
                    end
                end
                default:
                    push = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alloc         <= RST_ALLOC;
            consumed_size <= RST_SIZE;
            produced_size <= RST_SIZE;
        end
        else
        begin
            alloc         <= next_alloc;
            consumed_size <= next_csize;
            produced_size <= next_psize;
        end
    end

    // ------------------------------------------------------------
    // Answer buffer
    // ------------------------------------------------------------
    // Accepting only with room means a stalled answer reader loses nothing
    dnsd_buf #(
        .W       ($bits(dnsd_rsp_s))
    ) u_buf (
        .mclk    (mclk),
        .reset_n (reset_n),
        .s_valid (push),
        .s_ready (req_ready),
        .s_data  (push_data),
        .m_valid (rsp_valid),
        .m_ready (rsp_ready),
        .m_data  (rsp)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_dup;
        accept && own && req.id[2:0] == MSG_DUPCHK |-> push && push_data.kind == K_DUPCHK;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate check not classified");

    property p_unconn_get;
        accept && own && req.id[2:0] == MSG_UNCONN && req.service == SVC_GET
            |-> push && push_data.status == ST_SVC_NS;
    endproperty
    a_unconn_get: assert property (p_unconn_get) else $error("unconnected get not refused");

    property p_poll;
        accept && own && req.id[2:0] == MSG_POLL |-> push == alloc[AL_POLL];
    endproperty
    a_poll: assert property (p_poll) else $error("poll dispatch wrong");

    property p_expl;
        accept && own && req.id[2:0] == MSG_EXPL && !alloc[AL_EXPL] |-> !push;
    endproperty
    a_expl: assert property (p_expl) else $error("explicit request without connection");

    property p_foreign;
        accept && req.id[8:3] != node_sync |-> !push;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign node answered");

    property p_alloc;
        accept && own && req.id[2:0] == MSG_UNCONN && req.service == SVC_ALLOC
            |=> (alloc & ($past(req.wdata[7:0]) & AL_MASK)) == ($past(req.wdata[7:0]) & AL_MASK);
    endproperty
    a_alloc: assert property (p_alloc) else $error("allocation not taken");

    property p_release;
        accept && own && req.service == SVC_RELEASE &&
            (req.id[2:0] == MSG_UNCONN || (req.id[2:0] == MSG_EXPL && alloc[AL_EXPL]))
            |=> (alloc & $past(req.wdata[7:0])) == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("release left connection");

    property p_pcode;
        push && push_data.kind == K_EXPL && push_data.service == SVC_GET && push_data.cls == CLS_IDENT
            && push_data.status == ST_OK |-> push_data.data == PRODUCT_CODE;
    endproperty
    a_pcode: assert property (p_pcode) else $error("product code wrong");

    property p_size;
        consumed_size != 8'h00 && produced_size != 8'h00;
    endproperty
    a_size: assert property (p_size) else $error("size out of range");

    property p_queue;
        push && !rsp_ready ##1 push && !rsp_ready |=> !req_ready;
    endproperty
    a_queue: assert property (p_queue) else $error("buffer accepted beyond two");

endmodule
`default_nettype wire

// *** dnsd_master.sv ***
// Network master stand-in: request driver and answer reader
`timescale 1ns/10ps
`default_nettype none
module dnsd_master (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // Requests to the slave
    output var  logic                req_valid,
    input  wire logic                req_ready,
    output var  dnsd_pkg::dnsd_req_s req,
    // Answers from the slave
    input  wire logic                rsp_valid,
    output var  logic                rsp_ready,
    input  wire dnsd_pkg::dnsd_rsp_s rsp
);
    import dnsd_pkg::*;
    initial
    begin
        req_valid = 1'b0;
        rsp_ready = 1'b0;
        req       = '0;
    end
    // Request held until taken or for at most 20 edges; released bus shows inverse, not stale
    task automatic send(input dnsd_req_s r, output logic ok);
        @(posedge mclk);
        ok = 1'b0;
        req_valid <= 1'b1;
        req       <= r;
        for (int n = 0; n < 20 && ok !== 1'b1; n++)
        begin
            @(posedge mclk);
            ok = req_ready;
        end
        req_valid <= 1'b0;
        req       <= ~r;
    endtask
    // Two requests on consecutive edges; both must find room
    task automatic send_pair(input dnsd_req_s r0, input dnsd_req_s r1, output logic ok);
        @(posedge mclk);
        req_valid <= 1'b1;
        req       <= r0;
        @(posedge mclk);
        ok = req_ready;
        req       <= r1;
        @(posedge mclk);
        ok = ok & req_ready;
        req_valid <= 1'b0;
        req       <= ~r1;
    endtask
    // Reader stalls whenever this task is not running
    task automatic take(output dnsd_rsp_s r, output logic ok);
        @(posedge mclk);
        ok = 1'b0;
        rsp_ready <= 1'b1;
        for (int n = 0; n < 20 && ok !== 1'b1; n++)
        begin
            @(posedge mclk);
            ok = rsp_valid;
            r  = rsp;
        end
        rsp_ready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** devicenet_group2_slave_decoder_bench.sv ***
// Self-checking bench for the group 2 slave decoder
`timescale 1ns/10ps
`default_nettype none
module devicenet_group2_slave_decoder_bench;
    import dnsd_pkg::*;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam logic [15:0] PCODE = 16'h1234; // Arbitrary value
    localparam logic [5:0]  NODE  = 6'h2A;
    localparam logic [15:0] ANY   = 16'hXXXX;
    logic       mclk;
    logic       reset_n;
    logic [5:0] node_addr;
    logic       req_valid;
    logic       req_ready;
    dnsd_req_s  req;
    logic       rsp_valid;
    logic       rsp_ready;
    dnsd_rsp_s  rsp;
    logic [7:0] alloc;
    logic [7:0] consumed_size;
    logic [7:0] produced_size;
    int         error_cnt;
    int         checked;
    dnsd_top #(.PRODUCT_CODE(PCODE)) uut (.mclk(mclk), .reset_n(reset_n), .node_addr(node_addr),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp(rsp), .alloc(alloc), .consumed_size(consumed_size),
        .produced_size(produced_size));
    dnsd_master m (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    // ----------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    function automatic dnsd_req_s mk(input logic [2:0] c, input logic [7:0] s = 8'h00,
        input logic [7:0] cl = 8'h00, input logic [7:0] at = 8'h00, input logic [15:0] wd = 16'h0000);
        mk = '{{GROUP2, NODE, c}, s, cl, INST_ONE, at, wd};
    endfunction
    task automatic chkr(input dnsd_rsp_s a, input dnsd_kind_e k, input logic [7:0] st, input logic [15:0] d);
        chk(16'(a.kind), 16'(k), "kind");
        if (k == K_EXPL)
            chk(16'(a.status), 16'(st), "status");
        if (k != K_DUPCHK && d !== ANY)
            chk(a.data, d, "data");
    endtask
    task automatic xact(input dnsd_req_s r, output dnsd_rsp_s a);
        logic ok;
        m.send(r, ok);
        chk(16'(ok), 16'h0001, "request not taken");
        m.take(a, ok);
        chk(16'(ok), 16'h0001, "no answer");
        chk({a.service, a.cls}, {r.service, r.cls}, "service or class echo");
        if (ok !== 1'b1)
            close_out();
    endtask
    // Ignored request: answer would stay up since reader stalls
    task automatic quiet(input dnsd_req_s r);
        logic ok;
        m.send(r, ok);
        chk(16'(ok), 16'h0001, "request not taken");
        repeat (3) @(posedge mclk);
        chk(16'(rsp_valid), 16'h0000, "unexpected answer");
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        chk(16'(req_ready), 16'h0000, "ready in reset");
        chk({alloc, consumed_size}, 16'h0008, "alloc or consumed reset");
        chk(16'(produced_size), 16'h0008, "produced reset");
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(16'(req_ready), 16'h0001, "ready after reset");
    endtask
    task automatic t_dup;
        dnsd_rsp_s a;
        xact(mk(MSG_DUPCHK), a);
        chkr(a, K_DUPCHK, 8'h00, ANY);
    endtask
    task automatic t_ignore;
        dnsd_req_s r;
        r = mk(MSG_DUPCHK);
        r.id[8:3] = NODE ^ 6'h01;
        quiet(r);
        r.id = {2'h3, NODE, MSG_DUPCHK};
        quiet(r);
        for (int i = 0; i < 4; i++)
            quiet(mk(3'(i)));
        quiet(mk(MSG_POLL));
        quiet(mk(MSG_EXPL, SVC_GET, CLS_IDENT, ATTR_PCODE));
    endtask
    task automatic t_alloc;
        dnsd_rsp_s a;
        xact(mk(MSG_UNCONN, SVC_GET, CLS_IDENT, ATTR_PCODE), a);
        chkr(a, K_EXPL, ST_SVC_NS, ANY);
        xact(mk(MSG_UNCONN, SVC_ALLOC, CLS_CONN, 8'h00, 16'h00FF), a);
        chkr(a, K_EXPL, ST_OK, ANY);
        chk(16'(alloc), 16'h0017, "alloc bits");
    endtask
    task automatic t_poll(input logic [7:0] sz);
        dnsd_rsp_s a;
        xact(mk(MSG_POLL), a);
        chkr(a, K_POLL, 8'h00, {8'h00, sz});
    endtask
    task automatic t_get;
        dnsd_rsp_s a;
        logic [7:0] cl [4] = '{CLS_NET, CLS_CONN, CLS_CONSUME, CLS_PRODUCE};
        xact(mk(MSG_EXPL, SVC_GET, CLS_IDENT, ATTR_PCODE), a);
        chkr(a, K_EXPL, ST_OK, PCODE);
        for (int i = 0; i < 4; i++)
        begin
            xact(mk(MSG_EXPL, SVC_GET, cl[i], ATTR_PCODE), a);
            chkr(a, K_EXPL, ST_ATTR_NS, ANY);
        end
        xact(mk(MSG_EXPL, SVC_GET, 8'h02, ATTR_PCODE), a);
        chkr(a, K_EXPL, ST_NO_OBJ, ANY);
        xact(mk(MSG_EXPL, 8'h33, CLS_IDENT, ATTR_PCODE), a);
        chkr(a, K_EXPL, ST_SVC_NS, ANY);
    endtask
    task automatic t_sizes;
        dnsd_rsp_s a;
        xact(mk(MSG_EXPL, SVC_SET, CLS_CONN, ATTR_CSIZE, 16'h00FF), a);
        chkr(a, K_EXPL, ST_OK, ANY);
        xact(mk(MSG_EXPL, SVC_SET, CLS_CONN, ATTR_PSIZE, 16'h0001), a);
        chkr(a, K_EXPL, ST_OK, ANY);
        xact(mk(MSG_EXPL, SVC_SET, CLS_CONN, ATTR_PSIZE, 16'h0000), a);
        chkr(a, K_EXPL, ST_BAD_VAL, ANY);
        xact(mk(MSG_EXPL, SVC_SET, CLS_CONN, ATTR_CSIZE, 16'h0100), a);
        chkr(a, K_EXPL, ST_BAD_VAL, ANY);
        chk({consumed_size, produced_size}, 16'hFF01, "sizes");
        xact(mk(MSG_EXPL, SVC_GET, CLS_CONN, ATTR_PSIZE), a);
        chkr(a, K_EXPL, ST_OK, 16'h0001);
    endtask
    task automatic t_release;
        dnsd_rsp_s a;
        xact(mk(MSG_EXPL, SVC_RELEASE, CLS_CONN, 8'h00, 16'h0002), a);
        chkr(a, K_EXPL, ST_OK, ANY);
        chk(16'(alloc), 16'h0015, "alloc after release");
        quiet(mk(MSG_POLL));
    endtask
    // Node address moved: old address becomes foreign, new one answers
    task automatic t_node;
        dnsd_rsp_s a;
        dnsd_req_s r;
        node_addr <= NODE ^ 6'h15;
        repeat (3) @(posedge mclk);
        quiet(mk(MSG_DUPCHK));
        r = mk(MSG_DUPCHK);
        r.id[8:3] = NODE ^ 6'h15;
        xact(r, a);
        chkr(a, K_DUPCHK, 8'h00, ANY);
        node_addr <= NODE;
        repeat (3) @(posedge mclk);
    endtask
    // Two answers queued with the reader stalled; third request refused
    task automatic t_stall;
        dnsd_rsp_s a;
        logic ok;
        m.send_pair(mk(MSG_DUPCHK), mk(MSG_UNCONN, SVC_GET, CLS_IDENT, ATTR_PCODE), ok);
        chk(16'(ok), 16'h0001, "pair not taken");
        repeat (2) @(posedge mclk);
        chk(16'(req_ready), 16'h0000, "full buffer still ready");
        m.send(mk(MSG_DUPCHK), ok);
        chk(16'(ok), 16'h0000, "third request taken");
        m.take(a, ok);
        chkr(a, K_DUPCHK, 8'h00, ANY);
        m.take(a, ok);
        chkr(a, K_EXPL, ST_SVC_NS, ANY);
    endtask
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        checked   = 0;
        reset_n   = 1'b0;
        node_addr = NODE;
        repeat (2) @(posedge mclk);
        t_reset();
        t_dup();
        t_ignore();
        t_alloc();
        t_poll(8'h08);
        t_get();
        t_sizes();
        t_poll(8'hFF);
        t_release();
        t_node();
        t_stall();
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_dup();
        close_out();
    end
endmodule
`default_nettype wire
